// file: hdl/srsalu_core.sv
// Shift-right-logical and accumulator-subtract datapath slice with result,
// flag and write-back target outputs, plus a small control/status register port.
// Assumes the decoder presents opcode bytes and operands in the request cycle.
//
// Function
// - The shift moves each operand bit one place toward bit 0, result bits 0 to 6 taking the next higher bit.
// - The shift always puts zero into result bit 7.
// - The shift copies the operand's original bit 0 into carry.
// - The shift clears sign, half-carry and add/subtract, and sets zero only for an all-zero result.
// - The shift sets parity when the result has an even number of ones, else clears it.
// - The shift opcode is the bit prefix then 00 111 and an operand field, field 110 meaning the pointer pair.
// - In the indexed shift form one opcode bit picks the first or second index register, displacement before the op byte.
// - The subtract writes accumulator minus source back to the accumulator and leaves the source alone.
// - The subtract accepts all ten source operand modes.
// - The subtract sets sign for a negative difference and zero for a zero difference, clearing each otherwise.
// - The subtract sets half-carry on a borrow from bit 4, else clears it.
// - The subtract sets overflow only for opposite-signed operands with a result signed like the source.
// - The subtract sets add/subtract and sets carry on a borrow out of the top bit.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "srsalu_params.svh"

module srsalu_core (
	input  wire logic                       i_clock,
	input  wire logic                       i_resetn,
	input  wire logic                       i_req_valid,
	input  wire srsalu_pkg::srsalu_op_e     i_req_op,
	input  wire srsalu_pkg::srsalu_opcode_s i_opcode,
	input  wire srsalu_pkg::srsalu_mode_e   i_sub_mode,
	input  wire logic [7:0]                 i_acc,
	input  wire logic [7:0]                 i_operand,
	input  wire srsalu_pkg::srsalu_flags_s  i_flags,
	input  wire logic [3:0]                 i_reg_addr,
	input  wire logic [31:0]                i_reg_wdata,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	output logic [31:0]                     o_reg_rdata,
	output logic                            o_done,
	output logic                            o_bad,
	output logic [7:0]                      o_result,
	output srsalu_pkg::srsalu_flags_s       o_flags,
	output srsalu_pkg::srsalu_dest_s        o_dest
);

	srsalu_pkg::srsalu_state_s state_ff;
	srsalu_pkg::srsalu_state_s nxt_state;
	srsalu_pkg::srsalu_dec_s   dec;
	logic                      shift_go;
	logic                      sub_go;
	logic [8:0]                diff;
	logic [4:0]                low_diff;
	logic [7:0]                shifted;

	srsalu_opdec u_opdec (
		.i_opcode (i_opcode),
		.o_dec    (dec)
	);

	// Requests are only taken while enabled; an illegal shift opcode is flagged, not executed
	assign shift_go = i_req_valid && state_ff.enable && (i_req_op == srsalu_pkg::SRSALU_OP_SHIFT) && dec.legal;
	assign sub_go   = i_req_valid && state_ff.enable && (i_req_op == srsalu_pkg::SRSALU_OP_SUB);

	// Shifted byte: zero enters at the top
	assign shifted  = {1'b0, i_operand[7:1]};
	// Nine-bit difference exposes the borrow out of the top bit
	assign diff     = {1'b0, i_acc} - {1'b0, i_operand};
	assign low_diff = {1'b0, i_acc[3:0]} - {1'b0, i_operand[3:0]};

	// Next-state logic: datapath result, flags, write-back target and register port
	always_comb
	begin
		nxt_state       = state_ff;
		nxt_state.done  = 1'b0;
		nxt_state.bad   = 1'b0;
		if (shift_go)
		begin
			nxt_state.done     = 1'b1;
			nxt_state.result   = shifted;
			nxt_state.dest     = dec.dest;
			nxt_state.flags    = i_flags;
			nxt_state.flags.c  = i_operand[0];
			nxt_state.flags.s  = 1'b0;
			nxt_state.flags.h  = 1'b0;
			nxt_state.flags.n  = 1'b0;
			nxt_state.flags.z  = (shifted == 8'h00);
			nxt_state.flags.pv = ~^shifted;
			nxt_state.count    = state_ff.count + 8'h01;
		end
		else if (sub_go)
		begin
			// Any of the ten source modes is accepted alike; the operand byte is already fetched
			nxt_state.done      = 1'b1;
			nxt_state.last_mode = i_sub_mode;
			nxt_state.result    = diff[7:0];
			nxt_state.dest.kind = srsalu_pkg::SRSALU_D_ACC;
			nxt_state.dest.reg_field = 3'h0;
			nxt_state.dest.idx_sel   = 1'b0;
			nxt_state.dest.disp      = 8'h00;
			nxt_state.flags     = i_flags;
			nxt_state.flags.s   = diff[7];
			nxt_state.flags.z   = (diff[7:0] == 8'h00);
			nxt_state.flags.h   = low_diff[4];
			nxt_state.flags.pv  = (i_acc[7] != i_operand[7]) && (diff[7] == i_operand[7]);
			nxt_state.flags.n   = 1'b1;
			nxt_state.flags.c   = diff[8];
			nxt_state.count     = state_ff.count + 8'h01;
		end
		else if (i_req_valid && state_ff.enable)
		begin
			nxt_state.bad = 1'b1;
		end
		// Register writes; only the enable bit is writable
		if (i_reg_wr && (i_reg_addr == `SRSALU_ADDR_CTRL))
		begin
			nxt_state.enable = i_reg_wdata[`SRSALU_CTRL_EN_BIT];
		end
		// Read data held until the next read; unmapped offsets read zero
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				`SRSALU_ADDR_CTRL:   nxt_state.rdata = {31'h0000_0000, state_ff.enable};
				`SRSALU_ADDR_STATUS: nxt_state.rdata = {20'h0_0000, state_ff.last_mode, state_ff.flags};
				`SRSALU_ADDR_COUNT:  nxt_state.rdata = {24'h00_0000, state_ff.count};
				default:             nxt_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_ff           <= '0;
			state_ff.enable    <= `SRSALU_CTRL_RESET;
			state_ff.last_mode <= srsalu_pkg::SRSALU_M_REG;
			state_ff.dest.kind <= srsalu_pkg::SRSALU_D_REG;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// All data outputs come straight from the state register
	assign o_reg_rdata = state_ff.rdata;
	assign o_done      = state_ff.done;
	assign o_bad       = state_ff.bad;
	assign o_result    = state_ff.result;
	assign o_flags     = state_ff.flags;
	assign o_dest      = state_ff.dest;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	// Shift moves bits down and the answer lands exactly one cycle later
	chk_shift_bits_move: assert property (shift_go |=> o_done && (o_result[6:0] == $past(i_operand[7:1])))
		else $error("shift result bits 0 to 6 wrong");
	chk_shift_top_zero: assert property (shift_go |=> (o_result[7] == 1'b0))
		else $error("shift result bit 7 not zero");
	chk_shift_carry_out: assert property (shift_go |=> (o_flags.c == $past(i_operand[0])))
		else $error("shift carry not old bit 0");
	chk_shift_flag_set: assert property (shift_go |=> !o_flags.s && !o_flags.h && !o_flags.n &&
		(o_flags.z == (o_result == 8'h00)))
		else $error("shift sign, half, subtract or zero flag wrong");
	chk_shift_parity_even: assert property (shift_go |=> (o_flags.pv == ~^o_result))
		else $error("shift parity flag wrong");
	chk_shift_mem_pick: assert property (shift_go && (i_opcode.b0 == `SRSALU_PREFIX_BIT) &&
		(i_opcode.b1[2:0] == `SRSALU_FIELD_MEM) |=> (o_dest.kind == srsalu_pkg::SRSALU_D_MEM))
		else $error("pointer pair form not selected");
	chk_index_reg_pick: assert property (shift_go && (i_opcode.b1 == `SRSALU_PREFIX_BIT) |=>
		(o_dest.kind == srsalu_pkg::SRSALU_D_IDX) && (o_dest.idx_sel == $past(i_opcode.b0[5])) &&
		(o_dest.disp == $past(i_opcode.b2)))
		else $error("index register or displacement wrong");
	chk_sub_diff_value: assert property (sub_go |=> (o_result == 8'($past(i_acc) - $past(i_operand))) &&
		(o_dest.kind == srsalu_pkg::SRSALU_D_ACC))
		else $error("subtract difference wrong");
	chk_sub_any_mode: assert property (sub_go |=> o_done && !o_bad)
		else $error("subtract source mode refused");
	chk_sub_sign_zero: assert property (sub_go |=> (o_flags.s == o_result[7]) &&
		(o_flags.z == (o_result == 8'h00)))
		else $error("subtract sign or zero flag wrong");
	chk_sub_half_borrow: assert property (sub_go |=>
		(o_flags.h == ($past(i_acc[3:0]) < $past(i_operand[3:0]))))
		else $error("subtract half-carry wrong");
	chk_sub_overflow: assert property (sub_go |=>
		(o_flags.pv == (($past(i_acc[7]) != $past(i_operand[7])) && (o_result[7] == $past(i_operand[7])))))
		else $error("subtract overflow wrong");
	chk_sub_borrow_out: assert property (sub_go |=> o_flags.n &&
		(o_flags.c == ($past(i_acc) < $past(i_operand))))
		else $error("subtract carry or add/subtract flag wrong");
	chk_undef_flags_keep: assert property ((shift_go || sub_go) |=> (o_flags.u5 == $past(i_flags.u5)) &&
		(o_flags.u3 == $past(i_flags.u3)))
		else $error("undefined flag bits changed");

	// Plain register form must name its own source as the write-back target
	chk_shift_dest_same: assert property (shift_go && (i_opcode.b0 == `SRSALU_PREFIX_BIT) &&
		(i_opcode.b1[2:0] != `SRSALU_FIELD_MEM) |=> (o_dest.kind == srsalu_pkg::SRSALU_D_REG) &&
		(o_dest.reg_field == $past(i_opcode.b1[2:0])))
		else $error("shift result not sent back to its source register");
	// A code outside the shift pattern is flagged and must not disturb the last answer
	chk_shift_code_refuse: assert property (i_req_valid && state_ff.enable && !dec.legal &&
		(i_req_op == srsalu_pkg::SRSALU_OP_SHIFT) |=> o_bad && !o_done && $stable(o_result) && $stable(o_flags))
		else $error("illegal shift code not refused");
	// Status keeps the source form of the latest subtract for software to inspect
	chk_sub_mode_logged: assert property (sub_go |=> (state_ff.last_mode == $past(i_sub_mode)))
		else $error("subtract source mode not recorded");

endmodule
`default_nettype wire

// file: hdl/srsalu_params.svh
// Constants for the shift/subtract datapath slice: register offsets, field positions,
// reset values and opcode patterns. Assumes inclusion by bare name from hdl/.
`ifndef SRSALU_PARAMS_SVH
`define SRSALU_PARAMS_SVH

// Register port offsets (byte addresses, one word each)
`define SRSALU_ADDR_CTRL     4'h0
`define SRSALU_ADDR_STATUS   4'h4
`define SRSALU_ADDR_COUNT    4'h8

// Control register fields and reset values
`define SRSALU_CTRL_EN_BIT   0
`define SRSALU_CTRL_RESET    1'b1

// Flag byte positions
`define SRSALU_FLAG_S        7
`define SRSALU_FLAG_Z        6
`define SRSALU_FLAG_H        4
`define SRSALU_FLAG_PV       2
`define SRSALU_FLAG_N        1
`define SRSALU_FLAG_C        0

// Opcode patterns for the logical right shift
`define SRSALU_PREFIX_BIT    8'hcb
`define SRSALU_SHIFT_HI      5'h07
`define SRSALU_FIELD_MEM     3'h6
`define SRSALU_IDX_PREFIX    7'h7d
`define SRSALU_IDX_SEL_BIT   5
`define SRSALU_IDX_LAST      8'h3e

`endif

// file: hdl/srsalu_pkg.sv
// Types shared by the shift/subtract datapath slice and its opcode classifier.
// Assumes nothing beyond a SystemVerilog compiler.
package srsalu_pkg;

	// Operation requested by the decoder
	typedef enum logic [0:0] {
		SRSALU_OP_SHIFT = 1'b0,
		SRSALU_OP_SUB   = 1'b1
	} srsalu_op_e;

	// Source operand forms of the subtract
	typedef enum logic [3:0] {
		SRSALU_M_REG  = 4'h0,
		SRSALU_M_REGX = 4'h1,
		SRSALU_M_IMM  = 4'h2,
		SRSALU_M_IND  = 4'h3,
		SRSALU_M_DIR  = 4'h4,
		SRSALU_M_IDX  = 4'h5,
		SRSALU_M_SIDX = 4'h6,
		SRSALU_M_REL  = 4'h7,
		SRSALU_M_STK  = 4'h8,
		SRSALU_M_BIDX = 4'h9
	} srsalu_mode_e;

	// Where the result goes back
	typedef enum logic [1:0] {
		SRSALU_D_REG  = 2'h0,
		SRSALU_D_MEM  = 2'h1,
		SRSALU_D_IDX  = 2'h2,
		SRSALU_D_ACC  = 2'h3
	} srsalu_dest_e;

	typedef struct packed {
		logic s;
		logic z;
		logic u5;
		logic h;
		logic u3;
		logic pv;
		logic n;
		logic c;
	} srsalu_flags_s;

	// Opcode bytes in fetch order
	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
	} srsalu_opcode_s;

	typedef struct packed {
		srsalu_dest_e kind;
		logic [2:0]   reg_field;
		logic         idx_sel;
		logic [7:0]   disp;
	} srsalu_dest_s;

	typedef struct packed {
		logic         legal;
		srsalu_dest_s dest;
	} srsalu_dec_s;

	// Whole state of the datapath slice
	typedef struct packed {
		logic          enable;
		logic          done;
		logic          bad;
		logic [7:0]    result;
		srsalu_flags_s flags;
		srsalu_dest_s  dest;
		srsalu_mode_e  last_mode;
		logic [7:0]    count;
		logic [31:0]   rdata;
	} srsalu_state_s;

endpackage

// file: hdl/srsalu_opdec.sv
// Opcode classifier for the logical right shift: register, pointer-pair and
// short-indexed forms. Purely combinational; bytes arrive already fetched.
`timescale 1ns/1ns
`default_nettype none
`include "srsalu_params.svh"

module srsalu_opdec (
	input  wire srsalu_pkg::srsalu_opcode_s i_opcode,
	output srsalu_pkg::srsalu_dec_s         o_dec
);

	logic reg_form;
	logic idx_form;

	// Plain and pointer-pair forms share the prefix and the upper five bits
	assign reg_form = (i_opcode.b0 == `SRSALU_PREFIX_BIT) &&
		(i_opcode.b1[7:3] == `SRSALU_SHIFT_HI);
	// Indexed form: index prefix, shift prefix, displacement, then the operation byte
	assign idx_form = ({i_opcode.b0[7:6], i_opcode.b0[4:0]} == `SRSALU_IDX_PREFIX) &&
		(i_opcode.b1 == `SRSALU_PREFIX_BIT) && (i_opcode.b3 == `SRSALU_IDX_LAST);

	// Destination chosen from the operand field or the index selector
	always_comb
	begin
		o_dec.legal          = reg_form || idx_form;
		o_dec.dest.reg_field = i_opcode.b1[2:0];
		o_dec.dest.idx_sel   = 1'b0;
		o_dec.dest.disp      = 8'h00;
		o_dec.dest.kind      = srsalu_pkg::SRSALU_D_REG;
		if (idx_form)
		begin
			o_dec.dest.kind      = srsalu_pkg::SRSALU_D_IDX;
			o_dec.dest.reg_field = `SRSALU_FIELD_MEM;
			o_dec.dest.idx_sel   = i_opcode.b0[`SRSALU_IDX_SEL_BIT];
			o_dec.dest.disp      = i_opcode.b2;
		end
		else if (reg_form && (i_opcode.b1[2:0] == `SRSALU_FIELD_MEM))
		begin
			o_dec.dest.kind = srsalu_pkg::SRSALU_D_MEM;
		end
	end

endmodule
`default_nettype wire

// file: tb/srsalu_regfile_model.sv
// Far-side model: decoder register file feeding bytes and taking results back.
// Assumes the bench loads bytes through the load port and paces requests.
`timescale 1ns/1ns
`default_nettype none
module srsalu_regfile_model (
	input  wire logic                      i_clock,
	input  wire logic                      i_load,
	input  wire logic [3:0]                i_load_idx,
	input  wire logic [7:0]                i_load_val,
	input  wire logic [3:0]                i_src,
	input  wire logic                      i_done,
	input  wire logic [7:0]                i_result,
	input  wire srsalu_pkg::srsalu_flags_s i_new_flags,
	input  wire srsalu_pkg::srsalu_dest_s  i_dest,
	output logic [7:0]                     o_acc,
	output logic [7:0]                     o_operand,
	output srsalu_pkg::srsalu_flags_s      o_flags
);
	// 0..7 registers (6 is the pointed byte, 7 the accumulator), 8 indexed byte, 9 flags
	logic [7:0] rf_ff [0:9];

	// Known contents from time zero so no unknown reaches the datapath
	initial
	begin
		for (int i = 0; i < 10; i++)
			rf_ff[i] = 8'h00;
	end

	// Bytes are presented in the request cycle
	assign o_acc = rf_ff[7];
	assign o_operand = rf_ff[i_src];
	assign o_flags = rf_ff[9];

	// Write-back lands on the done edge, so a dependent request must wait a cycle
	always @(posedge i_clock)
	begin
		if (i_load)
			rf_ff[i_load_idx] <= i_load_val;
		else if (i_done)
		begin
			rf_ff[9] <= i_new_flags;
			case (i_dest.kind)
				2'h0: rf_ff[i_dest.reg_field] <= i_result;
				2'h1: rf_ff[6] <= i_result;
				2'h2: rf_ff[8] <= i_result;
				default: rf_ff[7] <= i_result;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/test_shift_right_and_subtract_alu.sv
// Self-checking bench: byte-level model of shift and subtract against the slice.
// Assumes the package and header in hdl/ and the register file model in tb/.
`timescale 1ns/1ns
`default_nettype none
`include "srsalu_params.svh"
module test_shift_right_and_subtract_alu;
	logic clk, rstn, vld, wr, rd, load, done, bad;
	srsalu_pkg::srsalu_op_e op;
	srsalu_pkg::srsalu_opcode_s opc;
	srsalu_pkg::srsalu_mode_e mode;
	srsalu_pkg::srsalu_flags_s fin, fout;
	srsalu_pkg::srsalu_dest_s dest;
	logic [3:0] addr, src, lidx;
	logic [31:0] wdata, rdata, seed;
	logic [7:0] acc, opd, res, lval, lastres;
	logic [7:0] mdl [0:9];
	int fail_count, tests_run, cnt, lmode, lflags;

	srsalu_core dut (.i_clock(clk), .i_resetn(rstn), .i_req_valid(vld), .i_req_op(op), .i_opcode(opc),
		.i_sub_mode(mode), .i_acc(acc), .i_operand(opd), .i_flags(fin), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_done(done),
		.o_bad(bad), .o_result(res), .o_flags(fout), .o_dest(dest));
	srsalu_regfile_model far (.i_clock(clk), .i_load(load), .i_load_idx(lidx), .i_load_val(lval),
		.i_src(src), .i_done(done), .i_result(res), .i_new_flags(fout), .i_dest(dest), .o_acc(acc),
		.o_operand(opd), .o_flags(fin));

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Preload one byte of the far side and mirror it in the model
	task automatic put(input logic [3:0] i, input logic [7:0] v);
		@(posedge clk);
		load <= 1'b1;
		lidx <= i;
		lval <= v;
		mdl[i] = v;
		@(posedge clk);
		load <= 1'b0;
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check("register", rdata, e);
	endtask

	// One operation; want 0 taken, 1 refused as illegal, 2 ignored while disabled
	task automatic go(input logic k, input srsalu_pkg::srsalu_opcode_s c, input logic [3:0] s, input int want);
		logic [7:0] a, v, r, f, e;
		logic [3:0] m;
		a = mdl[7];
		v = mdl[s];
		f = mdl[9];
		m = 4'(rnd() % 10);
		r = k ? a - v : {1'b0, v[7:1]};
		if (k)
			e = {r[7], (r == 8'h00), f[5], (a[3:0] < v[3:0]), f[3], (a[7] != v[7] && r[7] == v[7]), 1'b1, (a < v)};
		else
			e = {1'b0, (r == 8'h00), f[5], 1'b0, f[3], ~^r, 1'b0, v[0]};
		@(posedge clk);
		vld <= 1'b1;
		op <= srsalu_pkg::srsalu_op_e'(k);
		opc <= c;
		src <= s;
		mode <= srsalu_pkg::srsalu_mode_e'(m);
		@(posedge clk);
		vld <= 1'b0;
		#1;
		check("done", done, want == 0);
		check("bad", bad, want == 1);
		if (want != 0)
		begin
			check("kept result", res, lastres);
			return;
		end
		check("result", res, r);
		check("flags", fout, e);
		check("dest", dest.kind, k ? 2'h3 : c.b0 != 8'hcb ? 2'h2 : {1'b0, c.b1[2:0] == 3'h6});
		if (!k && c.b0 != 8'hcb)
			check("index", {dest.idx_sel, dest.disp}, {c.b0[5], c.b2});
		else if (!k)
			check("field", dest.reg_field, c.b1[2:0]);
		lastres = r;
		lflags = e;
		cnt++;
		if (k)
			lmode = m;
		mdl[k ? 4'h7 : s] = r;
		mdl[9] = e;
		@(posedge clk);
		#1;
		check("written", opd, (k && s != 4'h7) ? v : r);
		check("acc", acc, (k || s == 4'h7) ? r : a);
	endtask

	// Main sequence
	initial
	begin
		seed = 32'h38b3_b61b;
		{rstn, vld, wr, rd, load} = 5'h00;
		op = srsalu_pkg::SRSALU_OP_SHIFT;
		mode = srsalu_pkg::SRSALU_M_REG;
		{opc, addr, wdata, src, lidx, lval, lastres} = '0;
		{fail_count, tests_run, cnt, lmode, lflags} = '0;
		for (int i = 0; i < 10; i++)
			mdl[i] = 8'h00;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rreg(`SRSALU_ADDR_CTRL, 32'h0000_0001);
		rreg(`SRSALU_ADDR_STATUS, 32'h0000_0000);
		rreg(4'hc, 32'h0000_0000);
		for (int i = 0; i < 10; i++)
			put(4'(i), 8'(rnd()));
		for (int i = 0; i < 8; i++)
			go(1'b0, {8'hcb, 8'h38 | 8'(i), 16'(rnd())}, 4'(i), 0);
		for (int i = 0; i < 2; i++)
			go(1'b0, {i ? 8'hfd : 8'hdd, 8'hcb, 8'(rnd()), 8'h3e}, 4'h8, 0);
		// Zero result with a carry out, then a zero difference
		put(4'h6, 8'h01);
		go(1'b0, {8'hcb, 8'h3e, 16'h0000}, 4'h6, 0);
		put(4'h3, mdl[7]);
		go(1'b1, '0, 4'h3, 0);
		for (int i = 0; i < 80; i++)
		begin
			put(4'(rnd() % 10), 8'(rnd()));
			if (rnd() % 2)
				go(1'b1, '0, 4'(rnd() % 9), 0);
			else
				go(1'b0, {8'hcb, 8'h38 | 8'(i % 8), 16'h0000}, 4'(i % 8), 0);
		end
		// Neighbouring shift code is refused, then a disabled request is ignored
		go(1'b0, {8'hcb, 8'h28, 16'h0000}, 4'h0, 1);
		wreg(`SRSALU_ADDR_CTRL, 32'h0000_0000);
		go(1'b1, '0, 4'h1, 2);
		rreg(`SRSALU_ADDR_CTRL, 32'h0000_0000);
		wreg(`SRSALU_ADDR_CTRL, 32'h0000_0001);
		wreg(`SRSALU_ADDR_STATUS, 32'hffff_ffff);
		rreg(`SRSALU_ADDR_STATUS, (lmode << 8) | lflags);
		rreg(`SRSALU_ADDR_COUNT, cnt % 256);
		// Mid-run reset: enable comes back set and the op counter restarts
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		rreg(`SRSALU_ADDR_CTRL, 32'h0000_0001);
		rreg(`SRSALU_ADDR_COUNT, 32'h0000_0000);
		end_of_test();
	end

	// Watchdog well beyond the expected run of some five hundred cycles
	initial
	begin
		#(50 * 5000);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
